// file: logic/board_test_pkg.sv
// constants shared by the board test mode logic
package board_test_pkg;

  // pins that join the chain besides the frame and lad0 pins
  localparam int OTHER_PIN_COUNT = 86;
  // frame and lad0 also join the chain once the mode is active
  localparam int STRAP_PIN_COUNT = 2;
  // test mode is off after a power-on reset
  localparam logic TEST_MODE_RESET = 1'b0;
  // host reset pin is taken as released until seen low
  localparam logic HOST_RESET_N_RESET = 1'b1;
  // all pins but the chain output tristated while the chain owns the package
  localparam logic PIN_OE_N_OFF = 1'b1;
  // output enable level that drives a pin
  localparam logic PIN_OE_N_ON = 1'b0;

  // entry or exit decision taken at the host reset release
  typedef enum logic [0:0] {
    MODE_FUNCTIONAL = 1'b0,
    MODE_CHAIN_TEST = 1'b1
  } board_mode_t;

endpackage : board_test_pkg

// file: logic/xnor_chain.sv
// cascaded xnor reduction over the chain input pins
`timescale 1ns/1ps
`default_nettype none

module xnor_chain #(
  parameter int WIDTH = 88
) (
  input wire logic [WIDTH-1:0] chain_in,
  output logic chain_out
);

  // cascade from the highest pin down; the seed makes the result track plain
  // parity, so all-low gives low and, for an even width, all-high gives low
  function automatic logic cascade(input logic [WIDTH-1:0] bits);
    logic acc;
    acc = (WIDTH % 2 == 1) ? 1'b1 : 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      acc = ~(acc ^ bits[i]);
    end
    return acc;
  endfunction : cascade

  // no clock anywhere: the output follows the pins through gates alone
  assign chain_out = cascade(chain_in);

endmodule : xnor_chain

`default_nettype wire

// file: logic/board_test_top.sv
// board test mode: pin isolation, mode latch and chain output steering
`timescale 1ns/1ps
`default_nettype none

module board_test_top #(
  parameter int OTHER_PINS = board_test_pkg::OTHER_PIN_COUNT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic host_bus_reset_n,
  // frame pin, active low, shared with the strap
  input wire logic frame_n_in,
  input wire logic frame_n_out,
  input wire logic frame_n_oe_n,
  output logic frame_n_pin_out,
  output logic frame_n_pin_oe_n,
  // lad bit zero, shared with the strap
  input wire logic lad0_in,
  input wire logic lad0_out,
  input wire logic lad0_oe_n,
  output logic lad0_pin_out,
  output logic lad0_pin_oe_n,
  // every other chain pin, pad side in, functional side out
  input wire logic [OTHER_PINS-1:0] pin_in,
  input wire logic [OTHER_PINS-1:0] func_out,
  input wire logic [OTHER_PINS-1:0] func_oe_n,
  output logic [OTHER_PINS-1:0] pin_out,
  output logic [OTHER_PINS-1:0] pin_oe_n,
  // pad levels as seen by the functional logic
  output logic [OTHER_PINS-1:0] core_pin_in,
  output logic core_frame_n_in,
  output logic core_lad0_in,
  // tach-shared pin, also general io
  input wire logic chain_output_pin_in,
  input wire logic general_io_shared_pin_out,
  input wire logic general_io_shared_pin_oe_n,
  output logic chain_output_pin_out,
  output logic chain_output_pin_oe_n,
  output logic core_tach_in,
  // mode status for the rest of the chip
  output logic test_mode_active
);

  localparam int CHAIN_WIDTH = OTHER_PINS + board_test_pkg::STRAP_PIN_COUNT;

  board_test_pkg::board_mode_t mode;
  board_test_pkg::board_mode_t next_mode;
  logic host_reset_n_prev;
  logic host_reset_rise;
  logic strap_enter;
  logic in_test;
  logic [CHAIN_WIDTH-1:0] chain_in;
  logic chain_out;

  // release edge of the host reset; prev starts high so a pin already high
  // after power-on is not mistaken for a release
  assign host_reset_rise = host_bus_reset_n & ~host_reset_n_prev;
  assign strap_enter = ~frame_n_in & ~lad0_in;
  assign next_mode = host_reset_rise
    ? (strap_enter ? board_test_pkg::MODE_CHAIN_TEST : board_test_pkg::MODE_FUNCTIONAL)
    : mode;

  // mode latch; power-on reset always returns to functional mode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode <= board_test_pkg::MODE_FUNCTIONAL;
      host_reset_n_prev <= board_test_pkg::HOST_RESET_N_RESET;
      test_mode_active <= board_test_pkg::TEST_MODE_RESET;
    end else begin
      mode <= next_mode;
      host_reset_n_prev <= host_bus_reset_n;
      test_mode_active <= (next_mode == board_test_pkg::MODE_CHAIN_TEST);
    end
  end

  assign in_test = (mode == board_test_pkg::MODE_CHAIN_TEST);

  // chain excludes host reset, supplies and the output pin itself
  assign chain_in = {frame_n_in, lad0_in, pin_in};

  xnor_chain #(
    .WIDTH(CHAIN_WIDTH)
  ) u_chain (
    .chain_in(chain_in),
    .chain_out(chain_out)
  );

  // pad steering; combinational so the chain result reaches the pin with no
  // clock, at the cost of one mux level on every functional path
  assign pin_out = in_test ? '0 : func_out;
  assign pin_oe_n = in_test ? {OTHER_PINS{board_test_pkg::PIN_OE_N_OFF}} : func_oe_n;
  assign frame_n_pin_out = in_test ? 1'b0 : frame_n_out;
  assign frame_n_pin_oe_n = in_test ? board_test_pkg::PIN_OE_N_OFF : frame_n_oe_n;
  assign lad0_pin_out = in_test ? 1'b0 : lad0_out;
  assign lad0_pin_oe_n = in_test ? board_test_pkg::PIN_OE_N_OFF : lad0_oe_n;

  // functional logic sees quiet zeros while the pins belong to the chain
  assign core_pin_in = in_test ? '0 : pin_in;
  assign core_frame_n_in = in_test ? 1'b0 : frame_n_in;
  assign core_lad0_in = in_test ? 1'b0 : lad0_in;
  assign core_tach_in = in_test ? 1'b0 : chain_output_pin_in;

  // tach-shared pin: chain result in test mode, general io otherwise
  assign chain_output_pin_out = in_test ? chain_out : general_io_shared_pin_out;
  assign chain_output_pin_oe_n = in_test ? board_test_pkg::PIN_OE_N_ON : general_io_shared_pin_oe_n;

  // checks; the two release sequences feed the mode properties
  sequence seq_release_enter;
    host_reset_rise && !frame_n_in && !lad0_in;
  endsequence

  sequence seq_release_exit;
    host_reset_rise && (frame_n_in || lad0_in);
  endsequence

  chk_mode_entry: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    seq_release_enter |=> in_test && test_mode_active
  ) else $error("test mode not entered on strapped release");

  chk_mode_exit: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    seq_release_exit |=> !in_test && !test_mode_active
  ) else $error("test mode not left on release with strap high");

  chk_mode_holds: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !host_reset_rise |=> $stable(mode)
  ) else $error("mode changed without a host reset release");

  chk_por_clears: assert property (
    @(posedge core_clk)
    sys_rst |=> !in_test && !test_mode_active
  ) else $error("power-on reset left test mode active");

  chk_func_isolated: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test |-> (core_pin_in == '0) && !core_frame_n_in && !core_lad0_in && !core_tach_in
  ) else $error("functional logic still sees pins in test mode");

  chk_pins_input: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test |-> (&pin_oe_n) && frame_n_pin_oe_n && lad0_pin_oe_n && !chain_output_pin_oe_n
  ) else $error("pin direction wrong in test mode");

  chk_single_flip: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test && $past(in_test) && ($countones(chain_in ^ $past(chain_in)) == 1)
      |-> chain_output_pin_out != $past(chain_output_pin_out)
  ) else $error("single input flip did not flip chain output");

  chk_reset_excluded: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test && $past(in_test) && (chain_in == $past(chain_in))
      |-> chain_output_pin_out == $past(chain_output_pin_out)
  ) else $error("chain output moved with chain inputs steady");

  chk_strap_in_chain: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test && $past(in_test) && $stable(pin_in) && (frame_n_in != $past(frame_n_in)) && $stable(lad0_in)
      |-> chain_output_pin_out != $past(chain_output_pin_out)
  ) else $error("frame pin not acting as chain input");

  chk_all_low: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test && (chain_in == '0) |-> !chain_output_pin_out
  ) else $error("chain output high with all inputs low");

  chk_all_high: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test && (&chain_in) |-> !chain_output_pin_out
  ) else $error("chain output high with all inputs high");

  chk_after_exit: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_test |-> (chain_output_pin_out == general_io_shared_pin_out)
      && (chain_output_pin_oe_n == general_io_shared_pin_oe_n)
  ) else $error("chain still steers output pin outside test mode");

  chk_chain_parity: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test |-> chain_output_pin_out == (^chain_in)
  ) else $error("chain output is not the xnor cascade of its inputs");

  // functional drive stays off every pad that the chain owns
  chk_func_drive_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test |-> (pin_out == '0) && !frame_n_pin_out && !lad0_pin_out
  ) else $error("functional drive reached a pad in test mode");

  // outside test mode the pads and the functional logic see each other again
  chk_pads_passthru: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_test |-> (pin_out == func_out) && (pin_oe_n == func_oe_n) && (core_pin_in == pin_in)
      && (core_tach_in == chain_output_pin_in)
  ) else $error("pads not handed back to the functional logic");

  // host reset and the output pin's own pad level never move the chain result
  chk_excluded_pins: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    in_test && $past(in_test) && $stable(chain_in)
      && ($changed(host_bus_reset_n) || $changed(chain_output_pin_in))
      |-> $stable(chain_output_pin_out)
  ) else $error("excluded pin moved the chain output");

  // once out, a former chain input alone must leave the output pin still
  chk_exit_quiet: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !in_test && !$past(in_test) && $stable(general_io_shared_pin_out) && !$stable(chain_in)
      |-> $stable(chain_output_pin_out)
  ) else $error("former chain input moved the output pin after exit");

endmodule : board_test_top

`default_nettype wire

// file: sim/board_tester.sv
// board test equipment model: drives the pads and the host reset
`timescale 1ns/1ps
`default_nettype none
module board_tester #(
  parameter int N = 86
) (
  input wire logic core_clk,
  output logic host_bus_reset_n,
  output logic frame_n_in,
  output logic lad0_in,
  output logic [N-1:0] pin_in
);
  // pads start grounded, as on the test fixture
  initial begin
    host_bus_reset_n = 1'b1;
    {frame_n_in, lad0_in, pin_in} = '0;
  end
  // a low sample must precede each release, else no edge is seen
  task automatic strap(input logic f, input logic l);
    @(posedge core_clk) #1 host_bus_reset_n = 1'b0;
    frame_n_in = f;
    lad0_in = l;
    @(posedge core_clk) #1 host_bus_reset_n = 1'b1;
    @(posedge core_clk) #1;
  endtask : strap
endmodule : board_tester
`default_nettype wire

// file: sim/tb_top.sv
// testbench for the board test mode block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  localparam int N = board_test_pkg::OTHER_PIN_COUNT;
  int n_checks = 0;
  int n_mismatch = 0;
  logic core_clk, sys_rst, host_bus_reset_n, frame_n_in, lad0_in, chain_output_pin_in;
  logic [N-1:0] pin_in, pin_out, pin_oe_n, core_pin_in;
  logic frame_n_pin_out, frame_n_pin_oe_n, lad0_pin_out, lad0_pin_oe_n, core_frame_n_in, core_lad0_in;
  logic chain_output_pin_out, chain_output_pin_oe_n, core_tach_in, test_mode_active;
  logic fo = 1'b1;
  logic fe = 1'b0;
  logic [N+1:0] v;
  board_test_top u_dut (.core_clk, .sys_rst, .host_bus_reset_n, .frame_n_in, .frame_n_out(fo),
    .frame_n_oe_n(fe), .frame_n_pin_out, .frame_n_pin_oe_n, .lad0_in, .lad0_out(fo), .lad0_oe_n(fe),
    .lad0_pin_out, .lad0_pin_oe_n, .pin_in, .func_out({N{fo}}), .func_oe_n({N{fe}}), .pin_out, .pin_oe_n,
    .core_pin_in, .core_frame_n_in, .core_lad0_in, .chain_output_pin_in, .general_io_shared_pin_out(fo),
    .general_io_shared_pin_oe_n(fe), .chain_output_pin_out, .chain_output_pin_oe_n, .core_tach_in,
    .test_mode_active);
  board_tester #(.N(N)) u_tester (.core_clk, .host_bus_reset_n, .frame_n_in, .lad0_in, .pin_in);
  // free running clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  // enter with both straps low: pads isolated, chain output driven low
  task automatic t_enter();
    u_tester.strap(1'b0, 1'b0);
    `CHK(test_mode_active, 1'b1)
    `CHK(chain_output_pin_out, 1'b0)
    `CHK({pin_oe_n, frame_n_pin_oe_n, lad0_pin_oe_n, chain_output_pin_oe_n}, {{(N+2){1'b1}}, 1'b0})
    `CHK({core_pin_in, core_frame_n_in, core_lad0_in, core_tach_in}, '0)
    `CHK({pin_out, frame_n_pin_out, lad0_pin_out}, '0)
    $display("t_enter done");
  endtask : t_enter
  // flip each input down the chain, then back up; output follows at once
  task automatic t_walk();
    v = '0;
    for (int j = 0; j < 2 * (N + 2); j++) begin
      @(posedge core_clk) #1 v[j < N + 2 ? N + 1 - j : j - N - 2] ^= 1'b1;
      {u_tester.frame_n_in, u_tester.lad0_in, u_tester.pin_in} = v;
      #1 `CHK(chain_output_pin_out, ^v)
      if (j == N + 1) `CHK(chain_output_pin_out, 1'b0)
    end
    // excluded pins must not move the output; host reset left low here
    @(posedge core_clk) #1 chain_output_pin_in = 1'b1;
    u_tester.host_bus_reset_n = 1'b0;
    #1 `CHK(chain_output_pin_out, 1'b0)
    `CHK(test_mode_active, 1'b1)
    $display("t_walk done");
  endtask : t_walk
  // leave via either strap high; former chain pins then dead
  task automatic t_exit();
    for (int k = 0; k < 2; k++) begin
      u_tester.strap(1'b0, 1'b0);
      `CHK(test_mode_active, 1'b1)
      u_tester.strap(k == 0, k == 1);
      `CHK(test_mode_active, 1'b0)
      `CHK(pin_oe_n, {N{fe}})
      `CHK({core_pin_in, core_tach_in}, {u_tester.pin_in, chain_output_pin_in})
      `CHK(chain_output_pin_out, fo)
      // one pin only, so a chain still steering the pin would flip it
      @(posedge core_clk) #1 u_tester.pin_in[k] = ~u_tester.pin_in[k];
      #1 `CHK(chain_output_pin_out, fo)
    end
    $display("t_exit done");
  endtask : t_exit
  // power-on reset alone clears the mode
  task automatic t_por();
    u_tester.strap(1'b0, 1'b0);
    `CHK(test_mode_active, 1'b1)
    sys_rst = 1'b1;
    @(posedge core_clk) #1 sys_rst = 1'b0;
    `CHK(test_mode_active, 1'b0)
    `CHK({chain_output_pin_out, chain_output_pin_oe_n}, {fo, fe})
    // no false release may follow the power-on reset
    @(posedge core_clk) #1 `CHK(test_mode_active, 1'b0)
    $display("t_por done");
  endtask : t_por
  // watchdog: the tests take some two hundred cycles, so 2000 means a hang
  initial begin
    repeat (2000) @(posedge core_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    sys_rst = 1'b1;
    chain_output_pin_in = 1'b0;
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    t_enter();
    t_walk();
    t_exit();
    t_por();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
